//--- psl_map.svh
/*
  Constants of the synthesizer serial loader: word layout, field positions,
  reset values, legal limits and timing figures.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef PSL_MAP_SVH
`define PSL_MAP_SVH

// Serial word size and latch select position
`define PSL_WORD_W 19
`define PSL_SEL_BIT 0
`define PSL_SEL_REF 1'b1

// Reference word fields, operation bits first
`define PSL_CP_BIT 18
`define PSL_LDS_BIT 17
`define PSL_FC_BIT 16
`define PSL_MOD_BIT 15
`define PSL_R_MSB 14
`define PSL_R_LSB 1

// Counter word fields
`define PSL_P_MSB 18
`define PSL_P_LSB 8
`define PSL_S_MSB 7
`define PSL_S_LSB 1

// Field widths
`define PSL_R_W 14
`define PSL_P_W 11
`define PSL_S_W 7
`define PSL_RATIO_W 18

// Lowest legal divider values
`define PSL_P_MIN 11'h003
`define PSL_R_MIN 14'h0003

// Reset values of the latches
`define PSL_R_RST 14'h0000
`define PSL_P_RST 11'h000
`define PSL_S_RST 7'h00

// Loop settling time and core clock rate
`define PSL_LOCK_SETTLE_US 1000
`define PSL_CLK_MHZ 100

`endif

//--- psl_pkg.sv
/*
  Types of the synthesizer serial loader.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package psl_pkg;

  // Loop state as seen by the lock output
  typedef enum logic [1:0] {
    psl_st_idle,
    psl_st_settle,
    psl_st_locked,
    psl_st_unlocked
  } psl_lock_state_t;

endpackage : psl_pkg
`default_nettype wire

//--- psl_shift_reg.sv
/*
  Serial shift register on the link clock.
  Assumes data is stable around each rising serial clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psl_map.svh"

module psl_shift_reg (
  // Link clock and data
  input wire logic i_sclk,
  input wire logic i_sdata,
  // Shifted word
  output logic [`PSL_WORD_W-1:0] o_word
);

  ////////////////////////////////////////////////////////////////////////
  // Shift path
  ////////////////////////////////////////////////////////////////////////

  logic [`PSL_WORD_W-1:0] word_d; // Next shift contents
  logic [`PSL_WORD_W-1:0] word_q; // Shift contents

  // New bit enters at the bottom, oldest falls off the top
  always_comb begin
    word_d = {word_q[`PSL_WORD_W-2:0], i_sdata};
  end

  // Data only, so no reset: the link clock may not run at reset
  always_ff @(posedge i_sclk) begin
    word_q <= word_d;
  end

  assign o_word = word_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////////

  logic [`PSL_WORD_W-2:0] low_bits; // Helper for the shift check
  assign low_bits = word_q[`PSL_WORD_W-2:0];

  property p_shift_in;
    @(posedge i_sclk) disable iff (1'b0)
    ##1 (word_q === {$past(low_bits), $past(i_sdata)});
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in");

endmodule : psl_shift_reg
`default_nettype wire

//--- psl_loader.sv
/*
  Synthesizer serial loader: shift register on the link clock, latch
  transfer on the load strobe, divider outputs and lock indicator.
  Assumes the host keeps the serial clock still while the load strobe is
  high, so the shifted word is steady when the core clock samples it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psl_map.svh"

module psl_loader #(
  parameter int SETTLE_CYC = `PSL_LOCK_SETTLE_US * `PSL_CLK_MHZ
) (
  // Core clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Serial link
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_load_strobe,
  // Reference latch
  output logic [`PSL_R_W-1:0] o_ref_div,
  output logic o_cp_sel,
  output logic o_out_function_sel,
  output logic o_comparator_polarity,
  output logic o_modulus_128,
  // Counter latch
  output logic [`PSL_P_W-1:0] o_prog_cnt,
  output logic [`PSL_S_W-1:0] o_swallow_cnt,
  // Status
  output logic [`PSL_RATIO_W-1:0] o_div_ratio,
  output logic o_ref_valid,
  output logic o_prog_valid,
  output logic o_cfg_legal,
  output logic o_lock_indicator
);

  localparam int CNT_W = $clog2(SETTLE_CYC + 1);

  // Refuse a settle time the counter cannot serve
  if (SETTLE_CYC < 2) begin : g_bad_settle
    $error("SETTLE_CYC must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////
  // Functions
  ////////////////////////////////////////////////////////////////////////

  // Divider values that the synthesizer can run with
  function automatic logic f_cfg_ok(input logic [`PSL_P_W-1:0] p,
                                    input logic [`PSL_S_W-1:0] s,
                                    input logic [`PSL_R_W-1:0] r);
    logic s_below_p; // Swallow under programmable
    s_below_p = ({4'h0, s} < p);
    return (p >= `PSL_P_MIN) && s_below_p && (r >= `PSL_R_MIN);
  endfunction : f_cfg_ok

  // Total division ratio from the counter fields
  function automatic logic [`PSL_RATIO_W-1:0] f_ratio(input logic [`PSL_P_W-1:0] p,
                                                      input logic [`PSL_S_W-1:0] s,
                                                      input logic m128);
    logic [`PSL_RATIO_W-1:0] mp; // Modulus times P
    mp = m128 ? {p, 7'h00} : {1'b0, p, 6'h00};
    return mp + {11'h000, s};
  endfunction : f_ratio

  ////////////////////////////////////////////////////////////////////////
  // Link side
  ////////////////////////////////////////////////////////////////////////

  logic [`PSL_WORD_W-1:0] link_word; // Word held on the link clock

  // Shift register on the serial clock
  psl_shift_reg u_shift (
    .i_sclk (i_sclk),
    .i_sdata (i_sdata),
    .o_word (link_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // Load strobe crossing
  ////////////////////////////////////////////////////////////////////////

  logic [1:0] ld_sync_d; // Next synchroniser stages
  logic [1:0] ld_sync_q; // Synchroniser, stage 0 feeds stage 1 only
  logic ld_prev_d; // Next delayed strobe
  logic ld_prev_q; // Delayed strobe for edge detect
  logic load_evt; // Rising edge of the strobe

  // Two stages, then an edge detect on the second
  always_comb begin
    ld_sync_d = {ld_sync_q[0], i_load_strobe};
    ld_prev_d = ld_sync_q[1];
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ld_sync_q <= 2'h0;
      ld_prev_q <= 1'b0;
    end else begin
      ld_sync_q <= ld_sync_d;
      ld_prev_q <= ld_prev_d;
    end
  end

  assign load_evt = ld_sync_q[1] & ~ld_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // Latches
  ////////////////////////////////////////////////////////////////////////

  logic [`PSL_R_W-1:0] ref_d, ref_q; // Reference divider
  logic cp_d, cp_q; // Charge pump select
  logic lds_d, lds_q; // Output function select
  logic fc_d, fc_q; // Comparator polarity
  logic mod_d, mod_q; // Prescaler modulus 128
  logic [`PSL_P_W-1:0] p_d, p_q; // Programmable counter
  logic [`PSL_S_W-1:0] s_d, s_q; // Swallow counter
  logic rv_d, rv_q; // Reference latch loaded
  logic pv_d, pv_q; // Counter latch loaded
  logic [`PSL_RATIO_W-1:0] ratio_d, ratio_q; // Division ratio
  logic legal_d, legal_q; // Both latches legal
  logic sel_ref; // Word goes to reference latch

  assign sel_ref = (link_word[`PSL_SEL_BIT] == `PSL_SEL_REF);

  // Word is steady while the strobe is high, so it is sampled directly
  always_comb begin
    ref_d = ref_q;
    cp_d = cp_q;
    lds_d = lds_q;
    fc_d = fc_q;
    mod_d = mod_q;
    p_d = p_q;
    s_d = s_q;
    rv_d = rv_q;
    pv_d = pv_q;
    if (load_evt && sel_ref) begin
      // Reference word, operation bits at the head
      cp_d = link_word[`PSL_CP_BIT];
      lds_d = link_word[`PSL_LDS_BIT];
      fc_d = link_word[`PSL_FC_BIT];
      mod_d = link_word[`PSL_MOD_BIT];
      ref_d = link_word[`PSL_R_MSB:`PSL_R_LSB];
      rv_d = 1'b1;
    end else if (load_evt) begin
      // Counter word
      p_d = link_word[`PSL_P_MSB:`PSL_P_LSB];
      s_d = link_word[`PSL_S_MSB:`PSL_S_LSB];
      pv_d = 1'b1;
    end
    // Ratio and legality follow the latches by one cycle
    ratio_d = f_ratio(p_q, s_q, mod_q);
    legal_d = rv_q && pv_q && f_cfg_ok(p_q, s_q, ref_q);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ref_q <= `PSL_R_RST;
      cp_q <= 1'b0;
      lds_q <= 1'b0;
      fc_q <= 1'b0;
      mod_q <= 1'b0;
      p_q <= `PSL_P_RST;
      s_q <= `PSL_S_RST;
      rv_q <= 1'b0;
      pv_q <= 1'b0;
      ratio_q <= {`PSL_RATIO_W{1'b0}};
      legal_q <= 1'b0;
    end else begin
      ref_q <= ref_d;
      cp_q <= cp_d;
      lds_q <= lds_d;
      fc_q <= fc_d;
      mod_q <= mod_d;
      p_q <= p_d;
      s_q <= s_d;
      rv_q <= rv_d;
      pv_q <= pv_d;
      ratio_q <= ratio_d;
      legal_q <= legal_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lock tracking
  ////////////////////////////////////////////////////////////////////////

  psl_pkg::psl_lock_state_t st_d, st_q; // Loop state
  logic [CNT_W-1:0] cnt_d, cnt_q; // Settle counter
  logic lock_d, lock_q; // Lock pin

  // Every load restarts settling; the loop only locks when legal
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      psl_pkg::psl_st_idle: begin
        cnt_d = '0;
      end
      psl_pkg::psl_st_settle: begin
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == CNT_W'(SETTLE_CYC - 1)) begin
          // Wrong polarity leaves the loop unlocked
          st_d = (legal_q && fc_q) ? psl_pkg::psl_st_locked
                                   : psl_pkg::psl_st_unlocked;
          cnt_d = '0;
        end
      end
      psl_pkg::psl_st_locked: begin
        cnt_d = '0;
      end
      psl_pkg::psl_st_unlocked: begin
        cnt_d = '0;
      end
      default: begin
        st_d = psl_pkg::psl_st_idle;
        cnt_d = '0;
      end
    endcase
    if (load_evt) begin
      st_d = psl_pkg::psl_st_settle;
      cnt_d = '0;
    end
    // Pin carries lock only when the lock function is selected
    lock_d = (st_d == psl_pkg::psl_st_locked) && !lds_d;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= psl_pkg::psl_st_idle;
      cnt_q <= '0;
      lock_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      lock_q <= lock_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  ////////////////////////////////////////////////////////////////////////

  assign o_ref_div = ref_q;
  assign o_cp_sel = cp_q;
  assign o_out_function_sel = lds_q;
  assign o_comparator_polarity = fc_q;
  assign o_modulus_128 = mod_q;
  assign o_prog_cnt = p_q;
  assign o_swallow_cnt = s_q;
  assign o_div_ratio = ratio_q;
  assign o_ref_valid = rv_q;
  assign o_prog_valid = pv_q;
  assign o_cfg_legal = legal_q;
  assign o_lock_indicator = lock_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////////

  logic [`PSL_P_W-1:0] word_p; // Counter field of the word
  logic [`PSL_R_W-1:0] word_r; // Reference field of the word
  logic [`PSL_RATIO_W-1:0] ratio_chk; // Expected ratio
  assign word_p = link_word[`PSL_P_MSB:`PSL_P_LSB];
  assign word_r = link_word[`PSL_R_MSB:`PSL_R_LSB];
  assign ratio_chk = (o_modulus_128 ? 18'h00080 : 18'h00040) * 18'(o_prog_cnt)
                     + 18'(o_swallow_cnt);

  property p_load_prog;
    @(posedge i_clk) disable iff (i_srst)
    (load_evt && !sel_ref) |=> (o_prog_cnt == $past(word_p)) && o_prog_valid;
  endproperty
  a_load_prog: assert property (p_load_prog) else $error("counter word not loaded");

  property p_load_ref;
    @(posedge i_clk) disable iff (i_srst)
    (load_evt && sel_ref) |=> (o_ref_div == $past(word_r)) && $stable(o_prog_cnt);
  endproperty
  a_load_ref: assert property (p_load_ref) else $error("reference word misrouted");

  property p_lock_p;
    @(posedge i_clk) disable iff (i_srst)
    o_lock_indicator |-> (o_prog_cnt >= `PSL_P_MIN);
  endproperty
  a_lock_p: assert property (p_lock_p) else $error("lock with counter below three");

  property p_lock_s;
    @(posedge i_clk) disable iff (i_srst)
    o_lock_indicator |-> ({4'h0, o_swallow_cnt} < o_prog_cnt);
  endproperty
  a_lock_s: assert property (p_lock_s) else $error("lock with swallow not below P");

  property p_lock_r;
    @(posedge i_clk) disable iff (i_srst)
    o_lock_indicator |-> (o_ref_div >= `PSL_R_MIN) && o_ref_valid;
  endproperty
  a_lock_r: assert property (p_lock_r) else $error("lock with reference below three");

  property p_ratio;
    @(posedge i_clk) disable iff (i_srst)
    !$past(i_srst) |-> (o_div_ratio == $past(ratio_chk));
  endproperty
  a_ratio: assert property (p_ratio) else $error("division ratio wrong");

  property p_lock_drop;
    @(posedge i_clk) disable iff (i_srst)
    load_evt |=> !o_lock_indicator ##1 !o_lock_indicator;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock held across a load");

  property p_lock_rise;
    @(posedge i_clk) disable iff (i_srst)
    $rose(o_lock_indicator) |-> $past(st_q) == psl_pkg::psl_st_settle && o_cfg_legal;
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock rose without settling");

endmodule : psl_loader
`default_nettype wire

//--- psl_host_model.sv
/*
  Host side of the serial link: shifts words out and pulses the load strobe.
  Assumes the bench calls send_word and nothing else drives the link.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psl_map.svh"

module psl_host_model (
  // Serial link towards the loader
  output var logic o_sclk,
  output var logic o_sdata,
  output var logic o_load_strobe
);
  // Link clock half period, 80 ns period
  localparam time HALF = 40ns;
  // Preamble of alternating bit pairs, sent after the settle wait on entering transmit
  localparam logic [7:0] PREAMBLE = 8'hCC;

  // Path selects, active low; both idle high until the host picks one
  logic transmit_path_sel_n;
  logic receive_path_sel_n;
  logic tx_data; // Data towards the modulator

  // Link idle: clock still, strobe low, both paths off
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_load_strobe = 1'b0;
    transmit_path_sel_n = 1'b1;
    receive_path_sel_n = 1'b1;
    tx_data = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One word, most significant bit first, select bit last
  task automatic send_word(input logic [`PSL_WORD_W-1:0] w);
    #3;
    // Channel words only go out with the receiver selected
    transmit_path_sel_n = 1'b1;
    receive_path_sel_n = 1'b0;
    for (int i = `PSL_WORD_W - 1; i >= 0; i--) begin
      o_sdata = w[i];
      #HALF o_sclk = 1'b1;
      #HALF o_sclk = 1'b0;
    end
    // Released data line shows the inverse, not a held value
    o_sdata = ~o_sdata;
    #HALF o_load_strobe = 1'b1;
    // Clock stays still while strobe is high and just after
    #100ns o_load_strobe = 1'b0;
    #100ns;
  endtask : send_word

  // Leave receive, wait the scaled settle, send the preamble, return
  task automatic enter_transmit();
    receive_path_sel_n = 1'b1;
    transmit_path_sel_n = 1'b0;
    #(4 * HALF);
    for (int i = 7; i >= 0; i--) begin
      tx_data = PREAMBLE[i];
      #(2 * HALF);
    end
    // Back to receive on the same channel, scaled wait before data
    transmit_path_sel_n = 1'b1;
    receive_path_sel_n = 1'b0;
    #(4 * HALF);
  endtask : enter_transmit
endmodule : psl_host_model
`default_nettype wire

//--- test_pll_serial_channel_loader.sv
/*
  Self-checking bench of the serial loader, random and corner words.
  Assumes psl_loader, psl_host_model and psl_map.svh are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psl_map.svh"

module test_pll_serial_channel_loader;
  // Shortened settling count
  localparam int SETTLE = 20;
  // Channel plan in 250 Hz units: reference, offset, channel 429.5 MHz
  localparam int REF_U = 32'h0001_4C08;
  localparam int OFFSET_U = 32'h0001_5310;
  localparam int CHAN_U = 32'h001A_36F0;
  // Core clock, reset and link
  logic i_clk;
  logic i_srst;
  wire logic sclk;
  wire logic sdata;
  wire logic strobe;
  // Loader outputs
  logic [`PSL_R_W-1:0] o_ref_div;
  logic o_cp_sel, o_out_function_sel, o_comparator_polarity, o_modulus_128;
  logic [`PSL_P_W-1:0] o_prog_cnt;
  logic [`PSL_S_W-1:0] o_swallow_cnt;
  logic [`PSL_RATIO_W-1:0] o_div_ratio;
  logic o_ref_valid, o_prog_valid, o_cfg_legal, o_lock_indicator;
  // Counters
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  psl_loader #(.SETTLE_CYC(SETTLE)) DUT (
    .i_clk(i_clk), .i_srst(i_srst), .i_sclk(sclk), .i_sdata(sdata),
    .i_load_strobe(strobe), .o_ref_div(o_ref_div), .o_cp_sel(o_cp_sel),
    .o_out_function_sel(o_out_function_sel),
    .o_comparator_polarity(o_comparator_polarity),
    .o_modulus_128(o_modulus_128), .o_prog_cnt(o_prog_cnt),
    .o_swallow_cnt(o_swallow_cnt), .o_div_ratio(o_div_ratio),
    .o_ref_valid(o_ref_valid), .o_prog_valid(o_prog_valid),
    .o_cfg_legal(o_cfg_legal), .o_lock_indicator(o_lock_indicator)
  );

  // Host partner on the link
  psl_host_model host (.o_sclk(sclk), .o_sdata(sdata), .o_load_strobe(strobe));

  ////////////////////////////////////////////////////////////////////////////
  // Core clock, 100 MHz
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string name, input logic [17:0] exp, input logic [17:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Counts and verdict
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Expected division ratio
  function automatic logic [17:0] ratio(input logic m, input logic [10:0] p,
                                        input logic [6:0] s);
    return (m ? 18'h00080 : 18'h00040) * 18'(p) + 18'(s);
  endfunction : ratio

  ////////////////////////////////////////////////////////////////////////////
  // Send both words in either order, check latches then lock
  task automatic run_case(input logic out_function_sel, input logic fc, input logic m,
                          input logic [13:0] r, input logic [10:0] p,
                          input logic [6:0] s, input logic ref_first);
    logic [18:0] wr;
    logic [18:0] wc;
    logic legal;
    wr = {1'b0, out_function_sel, fc, m, r, `PSL_SEL_REF};
    wc = {p, s, ~`PSL_SEL_REF};
    legal = (p >= 11'h003) && (18'(s) < 18'(p)) && (r >= 14'h0003);
    if (ref_first) begin
      host.send_word(wr);
      host.send_word(wc);
    end else begin
      host.send_word(wc);
      host.send_word(wr);
    end
    repeat (2) @(posedge i_clk);
    #1;
    check("ref_div", 18'(r), 18'(o_ref_div));
    check("cp_sel", 18'h00000, 18'(o_cp_sel));
    check("out_fn", 18'(out_function_sel), 18'(o_out_function_sel));
    check("polarity", 18'(fc), 18'(o_comparator_polarity));
    check("modulus", 18'(m), 18'(o_modulus_128));
    check("prog", 18'(p), 18'(o_prog_cnt));
    check("swallow", 18'(s), 18'(o_swallow_cnt));
    check("ratio", ratio(m, p, s), o_div_ratio);
    check("valid", 18'h00003, 18'({o_ref_valid, o_prog_valid}));
    check("legal", 18'(legal), 18'(o_cfg_legal));
    check("lock_settling", 18'h00000, 18'(o_lock_indicator));
    repeat (SETTLE + 10) @(posedge i_clk);
    #1;
    check("lock", 18'(legal && fc && !out_function_sel), 18'(o_lock_indicator));
  endtask : run_case

  // Divider words for one channel at a given comparison rate
  task automatic run_channel(input int comp_u);
    int n;
    int r;
    r = REF_U / comp_u;
    n = (CHAN_U - OFFSET_U) / comp_u;
    run_case(1'b0, 1'b1, 1'b0, 14'(r), 11'(n / 32'h40), 7'(n % 32'h40), 1'b0);
    check("chan_ratio", 18'(n), o_div_ratio);
  endtask : run_channel

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] rng;
    logic [10:0] p;
    logic [6:0] s;
    logic [13:0] r;
    rng = 32'h0000_0050;
    i_srst = 1'b1;
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    check("reset_valid", 18'h00000, 18'({o_ref_valid, o_prog_valid}));
    check("reset_lock", 18'h00000, 18'(o_lock_indicator));
    // Boundary and illegal settings
    run_case(1'b0, 1'b1, 1'b0, 14'h0003, 11'h003, 7'h02, 1'b1);
    run_case(1'b0, 1'b1, 1'b1, 14'h3FFF, 11'h7FF, 7'h7F, 1'b0);
    run_case(1'b0, 1'b1, 1'b0, 14'h06A4, 11'h005, 7'h05, 1'b1);
    run_case(1'b0, 1'b1, 1'b0, 14'h0002, 11'h1FD, 7'h30, 1'b0);
    run_case(1'b0, 1'b1, 1'b0, 14'h06A4, 11'h002, 7'h00, 1'b1);
    run_case(1'b0, 1'b0, 1'b0, 14'h06A4, 11'h1FD, 7'h30, 1'b1);
    run_case(1'b1, 1'b1, 1'b1, 14'h06A4, 11'h1FD, 7'h30, 1'b0);
    // Mid-run reset clears latches, ratio and lock
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    check("rst_valid", 18'h00000, 18'({o_ref_valid, o_prog_valid}));
    check("rst_ratio", 18'h00000, o_div_ratio);
    check("rst_lock", 18'h00000, 18'(o_lock_indicator));
    // Channel 429.5 MHz at each comparison rate
    run_channel(32'h19);
    run_channel(32'h32);
    run_channel(32'h64);
    // Random legal channels
    for (int k = 0; k < 12; k++) begin
      rng = xs(rng);
      p = 11'(32'h3 + rng % 32'h7FD);
      rng = xs(rng);
      s = 7'(rng % ((p < 11'h080) ? 32'(p) : 32'h80));
      rng = xs(rng);
      r = 14'(32'h3 + rng % 32'h3FFD);
      rng = xs(rng);
      run_case(1'b0, 1'b1, rng[0], r, p, s, rng[1]);
    end
    host.enter_transmit();
    print_verdict();
  end
endmodule : test_pll_serial_channel_loader
`default_nettype wire
